//--- design/pfs_upper_pin_select.sv
// Function select logic for the upper eight multiplexed port pins, with an AHB-Lite slave.
//
// Notes on behaviour
// - Pin 31 field: I/O, data 31, trigger.
// - Pin 30 field: I/O, data 30, accept output.
// - Pin 29 field: I/O, data 29, select 3.
// - Pin 28 field: I/O, data 28, select 2.
// - Pin 27 field: I/O, data 27, acknowledge 1.
// - Pin 26 field: I/O, data 26, acknowledge 0.
// - Pin 25 field: I/O, data 25, request 1.
// - Pin 24 field: I/O, data 24, request 0.
// - Single chip turns data selection into I/O.
// - ROM-less wide area 0 forces data pins.
// - Single chip turns pins 29-24 alternates into I/O.
// - Every field resets to general I/O.
// - Only power-on reset clears both registers.
// - Without pins, registers still read and write.
`timescale 1ns/10ps
`include "pfs_defs.svh"
module pfs_upper_pin_select (
  input  wire logic                      CLOCK_I,              // Block clock.
  input  wire logic                      SYS_RST_I,            // Power-on reset, active high.
  input  wire logic                      HSEL_I,               // Slave select.
  input  wire logic [31:0]               HADDR_I,              // Byte address.
  input  wire logic [1:0]                HTRANS_I,             // Transfer type.
  input  wire logic                      HWRITE_I,             // Write when high.
  input  wire logic [2:0]                HSIZE_I,              // Transfer size.
  input  wire logic [31:0]               HWDATA_I,             // Write data.
  input  wire logic                      HREADY_I,             // Bus ready.
  output logic      [31:0]               HRDATA_O,             // Read data.
  output logic                           HREADYOUT_O,          // Slave ready.
  output logic                           HRESP_O,              // Slave response.
  input  wire logic                      SINGLE_CHIP_I,        // Single-chip mode.
  input  wire logic                      ROM_OFF_I,            // On-chip ROM disabled.
  input  wire logic                      AREA0_WIDE_I,         // Area 0 is 32 bits wide.
  input  wire logic                      PINS_PRESENT_I,       // Package bonds these pins.
  input  wire logic [7:0]                PAD_IN_I,             // Pad levels, pin 24 at bit 0.
  output logic      [7:0]                PAD_OUT_O,            // Pad drive levels.
  output logic      [7:0]                PAD_OE_N_O,           // Pad enables, low drives.
  input  wire logic [7:0]                GPIO_OUT_I,           // Port output data.
  input  wire logic [7:0]                GPIO_DIR_I,           // Port direction, high is out.
  output logic      [7:0]                GPIO_IN_O,            // Port input data.
  input  wire logic [7:0]                DBUS_OUT_I,           // Bus data bits 31 to 24 out.
  input  wire logic                      DBUS_OE_I,            // Bus drives data.
  output logic      [7:0]                DBUS_IN_O,            // Bus data bits 31 to 24 in.
  input  wire logic                      IRQ_ACCEPTED_OUT_N_I, // Interrupt accepted, low.
  input  wire logic                      CHIP_SELECT_3_N_I,    // Chip select 3, low.
  input  wire logic                      CHIP_SELECT_2_N_I,    // Chip select 2, low.
  input  wire logic                      DMA_ACK_CH1_I,        // DMA acknowledge 1.
  input  wire logic                      DMA_ACK_CH0_I,        // DMA acknowledge 0.
  output logic                           ADC_TRIGGER_IN_N_O,   // Conversion trigger, low.
  output logic                           DMA_REQ_CH1_N_O,      // DMA request 1, low.
  output logic                           DMA_REQ_CH0_N_O,      // DMA request 0, low.
  output logic      [`PFS_REG_W-1:0]     SELECT_B_O            // Companion register value.
);

  // Bus data phase state.
  logic                      dph_valid_reg;   // A transfer is in its data phase.
  logic                      dph_valid_next;  // Next data phase flag.
  logic                      dph_write_reg;   // Data phase is a write.
  logic                      dph_write_next;  // Next write flag.
  logic [`PFS_ADDR_MSB:0]    dph_addr_reg;    // Address of the data phase.
  logic [`PFS_ADDR_MSB:0]    dph_addr_next;   // Next data phase address.
  logic [1:0]                dph_lanes_reg;   // Byte lanes written in the data phase.
  logic [1:0]                dph_lanes_next;  // Next byte lanes.

  // Select registers and bus answers.
  logic [`PFS_REG_W-1:0]     sel_a_reg;       // Select register for pins 31 to 24.
  logic [`PFS_REG_W-1:0]     sel_a_next;      // Next value of the first register.
  logic [`PFS_REG_W-1:0]     sel_b_reg;       // Companion select register.
  logic [`PFS_REG_W-1:0]     sel_b_next;      // Next value of the companion register.
  logic [31:0]               hrdata_reg;      // Registered read data.
  logic [31:0]               hrdata_next;     // Next read data.
  logic                      hreadyout_reg;   // Registered ready.
  logic                      hresp_reg;       // Registered response.

  // Pad input synchroniser and filter.
  logic [7:0]                pad_s1_reg;      // First stage, read by the second only.
  logic [7:0]                pad_s2_reg;      // Second stage.
  logic [7:0]                pad_s3_reg;      // Third stage.
  logic [7:0]                pad_filt_reg;    // Accepted pad levels.
  logic [7:0]                pad_filt_next;   // Next accepted levels.

  // Pin outputs.
  logic [7:0]                pad_out_reg;     // Registered drive levels.
  logic [7:0]                pad_out_next;    // Next drive levels.
  logic [7:0]                pad_oe_n_reg;    // Registered enables.
  logic [7:0]                pad_oe_n_next;   // Next enables.
  logic [7:0]                gpio_in_reg;     // Registered port input.
  logic [7:0]                gpio_in_next;    // Next port input.
  logic [7:0]                dbus_in_reg;     // Registered bus data input.
  logic [7:0]                dbus_in_next;    // Next bus data input.
  logic [7:0]                alt_in_reg;      // Registered alternate inputs.
  logic [7:0]                alt_in_next;     // Next alternate inputs.

  // Decoded functions and alternate output sources.
  pfs_pkg::pfs_fn_e          pin_fn [`PFS_NUM_PINS]; // Function of each pin.
  logic [7:0]                alt_out;         // Alternate output level per pin.
  logic                      addr_take;       // An address phase is taken this edge.
  localparam logic [7:0]     ALT_OUT_MASK = `PFS_ALT_OUT_MASK; // Pins whose alternate drives.

  // Gives the byte lanes of the low half word that a transfer touches.
  function automatic logic [1:0] pfs_lanes(input logic [2:0] size, input logic [1:0] addr);
    logic [1:0] lanes;
    // A word covers both lanes; a byte or half word in the upper half covers none.
    lanes = 2'h3;
    if (size == `PFS_HSIZE_BYTE)
    begin
      lanes = (addr == 2'h0) ? 2'h1 : ((addr == 2'h1) ? 2'h2 : 2'h0);
    end
    else if (size == `PFS_HSIZE_HALF)
    begin
      lanes = addr[1] ? 2'h0 : 2'h3;
    end
    return lanes;
  endfunction : pfs_lanes

  // Decides whether an address phase is taken at this edge.
  assign addr_take = HSEL_I && HREADY_I && HTRANS_I[`PFS_HTRANS_ACT_BIT];

  // Computes the data phase state and the register contents.
  always_comb
  begin
    dph_valid_next = addr_take;
    dph_write_next = dph_write_reg;
    dph_addr_next  = dph_addr_reg;
    dph_lanes_next = dph_lanes_reg;
    sel_a_next     = sel_a_reg;
    sel_b_next     = sel_b_reg;
    if (addr_take)
    begin
      // Capture the address phase for the following data phase.
      dph_write_next = HWRITE_I;
      dph_addr_next  = HADDR_I[`PFS_ADDR_MSB:0];
      dph_lanes_next = pfs_lanes(HSIZE_I, HADDR_I[1:0]);
    end
    if (dph_valid_reg && dph_write_reg)
    begin
      // Writes land in the data phase, lane by lane; other addresses are ignored.
      for (int b = 0; b < `PFS_REG_W / `PFS_BYTE_W; b++)
      begin
        if (dph_lanes_reg[b] && dph_addr_reg == `PFS_OFS_SEL_A)
        begin
          sel_a_next[b*`PFS_BYTE_W +: `PFS_BYTE_W] = HWDATA_I[b*`PFS_BYTE_W +: `PFS_BYTE_W];
        end
        if (dph_lanes_reg[b] && dph_addr_reg == `PFS_OFS_SEL_B)
        begin
          sel_b_next[b*`PFS_BYTE_W +: `PFS_BYTE_W] = HWDATA_I[b*`PFS_BYTE_W +: `PFS_BYTE_W];
        end
      end
    end
  end

  // Prepares read data at the address phase, using the values after a pending write.
  always_comb
  begin
    hrdata_next = hrdata_reg;
    if (addr_take && !HWRITE_I)
    begin
      // Unmapped addresses read as zero; stored values read back even without pins.
      hrdata_next = `PFS_RDATA_ZERO;
      if (HADDR_I[`PFS_ADDR_MSB:0] == `PFS_OFS_SEL_A)
      begin
        hrdata_next = {16'h0000, sel_a_next};
      end
      else if (HADDR_I[`PFS_ADDR_MSB:0] == `PFS_OFS_SEL_B)
      begin
        hrdata_next = {16'h0000, sel_b_next};
      end
    end
  end

  // Registers the bus state; only power-on reset clears the select registers.
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      dph_valid_reg <= 1'b0;
      dph_write_reg <= 1'b0;
      dph_addr_reg  <= '0;
      dph_lanes_reg <= 2'h0;
      sel_a_reg     <= `PFS_SEL_RESET;
      sel_b_reg     <= `PFS_SEL_RESET;
      hrdata_reg    <= `PFS_RDATA_ZERO;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= `PFS_RESP_OKAY;
    end
    else
    begin
      dph_valid_reg <= dph_valid_next;
      dph_write_reg <= dph_write_next;
      dph_addr_reg  <= dph_addr_next;
      dph_lanes_reg <= dph_lanes_next;
      sel_a_reg     <= sel_a_next;
      sel_b_reg     <= sel_b_next;
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= `PFS_RESP_OKAY;
    end
  end

  // One decoder per pin; pin 31 keeps its trigger and pin 30 is reserved in single chip.
  generate
    for (genvar gi = 0; gi < `PFS_NUM_PINS; gi++)
    begin : g_pin
      localparam pfs_pkg::pfs_fn_e SC_FN = (gi == `PFS_PIN_ADC) ? pfs_pkg::PFS_FN_ALT :
                                           ((gi == `PFS_PIN_IRQ) ? pfs_pkg::PFS_FN_NONE :
                                            pfs_pkg::PFS_FN_GPIO);
      pfs_sel_if sel_bus ();
      assign sel_bus.field       = sel_a_reg[gi*`PFS_FIELD_W +: `PFS_FIELD_W];
      assign sel_bus.single_chip = SINGLE_CHIP_I;
      assign sel_bus.rom_off     = ROM_OFF_I;
      assign sel_bus.area0_wide  = AREA0_WIDE_I;
      assign pin_fn[gi]          = sel_bus.fn;
      pfs_pin_decode #(
        .SC_ALT_FN (SC_FN)
      ) u_decode (
        .sel       (sel_bus)
      );
    end
  endgenerate

  // Gathers the alternate output sources in pin order; input pins give a high level.
  always_comb
  begin
    alt_out                = `PFS_PAD_IDLE;
    alt_out[`PFS_PIN_IRQ]  = IRQ_ACCEPTED_OUT_N_I;
    alt_out[`PFS_PIN_CS3]  = CHIP_SELECT_3_N_I;
    alt_out[`PFS_PIN_CS2]  = CHIP_SELECT_2_N_I;
    alt_out[`PFS_PIN_ACK1] = DMA_ACK_CH1_I;
    alt_out[`PFS_PIN_ACK0] = DMA_ACK_CH0_I;
  end

  // Accepts a pad level once the second and third stages agree.
  always_comb
  begin
    pad_filt_next = (pad_s2_reg & pad_s3_reg) | (pad_filt_reg & (pad_s2_reg | pad_s3_reg));
  end

  // Routes every pin according to its decoded function.
  always_comb
  begin
    pad_out_next  = `PFS_PIN_ZERO;
    pad_oe_n_next = `PFS_PAD_IDLE;
    gpio_in_next  = `PFS_PIN_ZERO;
    dbus_in_next  = `PFS_PIN_ZERO;
    alt_in_next   = `PFS_PAD_IDLE;
    for (int i = 0; i < `PFS_NUM_PINS; i++)
    begin
      case (pin_fn[i])
        pfs_pkg::PFS_FN_GPIO:
        begin
          // Port data and direction drive the pin.
          pad_out_next[i]  = GPIO_OUT_I[i];
          pad_oe_n_next[i] = ~GPIO_DIR_I[i];
          gpio_in_next[i]  = pad_filt_reg[i];
        end
        pfs_pkg::PFS_FN_DATA:
        begin
          // The external bus owns the pin as one data bit.
          pad_out_next[i]  = DBUS_OUT_I[i];
          pad_oe_n_next[i] = ~DBUS_OE_I;
          dbus_in_next[i]  = pad_filt_reg[i];
        end
        pfs_pkg::PFS_FN_ALT:
        begin
          // Output alternates drive; input alternates pass the pad level inward.
          pad_out_next[i]  = alt_out[i];
          pad_oe_n_next[i] = ~ALT_OUT_MASK[i];
          alt_in_next[i]   = pad_filt_reg[i];
        end
        default:
        begin
          // Reserved selection: the pin floats and nothing is passed in.
          pad_oe_n_next[i] = 1'b1;
        end
      endcase
    end
    if (!PINS_PRESENT_I)
    begin
      // Without bonded pins the settings have no effect on any pin.
      pad_oe_n_next = `PFS_PAD_IDLE;
      gpio_in_next  = `PFS_PIN_ZERO;
      dbus_in_next  = `PFS_PIN_ZERO;
      alt_in_next   = `PFS_PAD_IDLE;
    end
  end

  // Registers the synchroniser, the filter and all pin side outputs.
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      pad_s1_reg   <= `PFS_PAD_IDLE;
      pad_s2_reg   <= `PFS_PAD_IDLE;
      pad_s3_reg   <= `PFS_PAD_IDLE;
      pad_filt_reg <= `PFS_PAD_IDLE;
      pad_out_reg  <= `PFS_PIN_ZERO;
      pad_oe_n_reg <= `PFS_PAD_IDLE;
      gpio_in_reg  <= `PFS_PIN_ZERO;
      dbus_in_reg  <= `PFS_PIN_ZERO;
      alt_in_reg   <= `PFS_PAD_IDLE;
    end
    else
    begin
      pad_s1_reg   <= PAD_IN_I;
      pad_s2_reg   <= pad_s1_reg;
      pad_s3_reg   <= pad_s2_reg;
      pad_filt_reg <= pad_filt_next;
      pad_out_reg  <= pad_out_next;
      pad_oe_n_reg <= pad_oe_n_next;
      gpio_in_reg  <= gpio_in_next;
      dbus_in_reg  <= dbus_in_next;
      alt_in_reg   <= alt_in_next;
    end
  end

  // Drives the ports straight from their flip-flops.
  assign HRDATA_O           = hrdata_reg;
  assign HREADYOUT_O        = hreadyout_reg;
  assign HRESP_O            = hresp_reg;
  assign PAD_OUT_O          = pad_out_reg;
  assign PAD_OE_N_O         = pad_oe_n_reg;
  assign GPIO_IN_O          = gpio_in_reg;
  assign DBUS_IN_O          = dbus_in_reg;
  assign ADC_TRIGGER_IN_N_O = alt_in_reg[`PFS_PIN_ADC];
  assign DMA_REQ_CH1_N_O    = alt_in_reg[`PFS_PIN_REQ1];
  assign DMA_REQ_CH0_N_O    = alt_in_reg[`PFS_PIN_REQ0];
  assign SELECT_B_O         = sel_b_reg;

endmodule : pfs_upper_pin_select

//--- design/pfs_defs.svh
// Constants of the upper port pin function select block.
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

// Number of pins, width of one select field and width of one select register.
`define PFS_NUM_PINS        8
`define PFS_FIELD_W         2
`define PFS_REG_W           16

// Register byte offsets on the bus, decoded over the low address bits.
`define PFS_ADDR_MSB        11
`define PFS_OFS_SEL_A       12'h000
`define PFS_OFS_SEL_B       12'h004

// Reset value of both select registers.
`define PFS_SEL_RESET       16'h0000

// Select field codes.
`define PFS_CODE_GPIO       2'h0
`define PFS_CODE_DATA       2'h1
`define PFS_CODE_ALT        2'h2
`define PFS_CODE_RSVD       2'h3

// Bus constants: active transfer bit of htrans, transfer sizes, response, idle read data.
`define PFS_HTRANS_ACT_BIT  1
`define PFS_HSIZE_BYTE      3'h0
`define PFS_HSIZE_HALF      3'h1
`define PFS_RESP_OKAY       1'b0
`define PFS_RDATA_ZERO      32'h0000_0000
`define PFS_BYTE_W          8

// Pin positions inside the pin vectors: bit 0 is pin 24, bit 7 is pin 31.
`define PFS_PIN_ADC         7
`define PFS_PIN_IRQ         6
`define PFS_PIN_CS3         5
`define PFS_PIN_CS2         4
`define PFS_PIN_ACK1        3
`define PFS_PIN_ACK0        2
`define PFS_PIN_REQ1        1
`define PFS_PIN_REQ0        0

// Pins whose alternate function is an output.
`define PFS_ALT_OUT_MASK    8'h7C

// Idle level of pad samples and of the active-low alternate inputs.
`define PFS_PAD_IDLE        8'hFF
`define PFS_PIN_ZERO        8'h00

`endif

//--- design/pfs_pkg.sv
// Types shared by the pin function select modules.
package pfs_pkg;

  // Function that one pin finally carries, after mode overrides.
  typedef enum logic [3:0] {
    PFS_FN_GPIO = 4'h1,
    PFS_FN_DATA = 4'h2,
    PFS_FN_ALT  = 4'h4,
    PFS_FN_NONE = 4'h8
  } pfs_fn_e;

  // One 2-bit select field.
  typedef logic [1:0] pfs_field_t;

endpackage : pfs_pkg

//--- design/pfs_sel_if.sv
// Interface that carries one pin's select field and mode to its decoder.
`timescale 1ns/10ps
interface pfs_sel_if;

  pfs_pkg::pfs_field_t field;       // Select field of the pin.
  logic                single_chip; // Device runs in single-chip mode.
  logic                rom_off;     // On-chip ROM is disabled.
  logic                area0_wide;  // Area 0 is configured 32 bits wide.
  pfs_pkg::pfs_fn_e    fn;          // Decoded function of the pin.

  // The register side drives field and mode and reads the function.
  modport cfg (output field, output single_chip, output rom_off, output area0_wide, input fn);

  // The decoder reads field and mode and drives the function.
  modport dec (input field, input single_chip, input rom_off, input area0_wide, output fn);

endinterface : pfs_sel_if

//--- design/pfs_pin_decode.sv
// Decoder that turns one pin's select field and the operating mode into its function.
`timescale 1ns/10ps
`include "pfs_defs.svh"
module pfs_pin_decode #(
  parameter pfs_pkg::pfs_fn_e SC_ALT_FN = pfs_pkg::PFS_FN_GPIO // Alternate code in single chip.
) (
  pfs_sel_if.dec sel
);

  // The ROM-less wide area 0 override is checked first, then the field code is decoded with single-chip mode.
  always_comb
  begin
    if (sel.rom_off && sel.area0_wide)
    begin
      // A ROM-less part with a wide area 0 needs every upper data bit.
      sel.fn = pfs_pkg::PFS_FN_DATA;
    end
    else
    begin
      case (sel.field)
        `PFS_CODE_GPIO:
        begin
          // Plain general I/O.
          sel.fn = pfs_pkg::PFS_FN_GPIO;
        end
        `PFS_CODE_DATA:
        begin
          // No external bus exists in single-chip mode, so fall back to I/O.
          sel.fn = sel.single_chip ? pfs_pkg::PFS_FN_GPIO : pfs_pkg::PFS_FN_DATA;
        end
        `PFS_CODE_ALT:
        begin
          // Single-chip mode may replace the alternate function per pin.
          sel.fn = sel.single_chip ? SC_ALT_FN : pfs_pkg::PFS_FN_ALT;
        end
        default:
        begin
          // Reserved code leaves the pin undriven.
          sel.fn = pfs_pkg::PFS_FN_NONE;
        end
      endcase
    end
  end

endmodule : pfs_pin_decode

//--- verif/pfs_upper_pin_select_asserts.sv
// Concurrent checks on the ports of the upper port pin function select block.
`timescale 1ns/10ps
// Every port mirrors the block port of the same name.
module pfs_sel_chk (
  input  wire logic        CLOCK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic        HREADY_I,
  input  wire logic [31:0] HRDATA_O,
  input  wire logic        HREADYOUT_O,
  input  wire logic        HRESP_O,
  input  wire logic        SINGLE_CHIP_I,
  input  wire logic        ROM_OFF_I,
  input  wire logic        AREA0_WIDE_I,
  input  wire logic        PINS_PRESENT_I,
  input  wire logic [7:0]  PAD_OUT_O,
  input  wire logic [7:0]  PAD_OE_N_O,
  input  wire logic [7:0]  GPIO_OUT_I,
  input  wire logic [7:0]  GPIO_DIR_I,
  input  wire logic [7:0]  GPIO_IN_O,
  input  wire logic [7:0]  DBUS_OUT_I,
  input  wire logic        DBUS_OE_I,
  input  wire logic [7:0]  DBUS_IN_O,
  input  wire logic        ADC_TRIGGER_IN_N_O,
  input  wire logic        DMA_REQ_CH1_N_O,
  input  wire logic        DMA_REQ_CH0_N_O,
  input  wire logic [15:0] SELECT_B_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  logic wide; // ROM-less with a wide area 0 overrides every field.
  logic sc;   // Single-chip mode that is not overridden.
  assign wide = ROM_OFF_I && AREA0_WIDE_I;
  assign sc   = SINGLE_CHIP_I && !wide;
  chk_wide_data_drive: assert property (
    (wide && PINS_PRESENT_I && DBUS_OE_I) |=> (PAD_OE_N_O == 8'h00 && PAD_OUT_O == $past(DBUS_OUT_I)))
    else $error("wide area 0 did not force the data bus onto the pins");
  chk_wide_no_alt: assert property (wide [*6] |-> (GPIO_IN_O == 8'h00 &&
    ADC_TRIGGER_IN_N_O && DMA_REQ_CH1_N_O && DMA_REQ_CH0_N_O))
    else $error("port or alternate input active while data bus is forced");
  chk_single_dir_only: assert property (
    sc |=> ((~PAD_OE_N_O & ~$past(GPIO_DIR_I)) == 8'h00))
    else $error("single chip drove a pin that is not a port output");
  chk_single_gpio_lvl: assert property (
    sc |=> (((PAD_OUT_O ^ $past(GPIO_OUT_I)) & ~PAD_OE_N_O) == 8'h00))
    else $error("single chip drove a level other than the port data");
  chk_single_no_bus: assert property (sc [*6] |-> (DBUS_IN_O == 8'h00 &&
    DMA_REQ_CH1_N_O && DMA_REQ_CH0_N_O))
    else $error("single chip passed bus data or a DMA request");
  chk_absent_quiet: assert property (!PINS_PRESENT_I |=> PAD_OE_N_O == 8'hFF)
    else $error("pins driven on a package without them");
  chk_reset_clear: assert property (disable iff (1'b0) SYS_RST_I |=>
    (PAD_OE_N_O == 8'hFF && SELECT_B_O == 16'h0000 && HRDATA_O == 32'h0))
    else $error("reset left a register or pad enable set");
  chk_bus_okay: assert property (
    HREADYOUT_O && !HRESP_O && HRDATA_O[31:16] == 16'h0000)
    else $error("bus answer not ready, not okay or upper half set");
  chk_read_hold: assert property (
    !(HREADY_I && HTRANS_I[1] && !HWRITE_I) |=> $stable(HRDATA_O))
    else $error("read data moved without a read");
endmodule : pfs_sel_chk

//--- verif/pfs_pad_partner.sv
// Far-side model of the pads: the external drivers of the released pins.
`timescale 1ns/10ps
module pfs_pad_partner (
  input  wire logic [7:0] pad_out_i,  // Block drive levels.
  input  wire logic [7:0] pad_oe_n_i, // Block enables, low drives.
  input  wire logic [7:0] ext_i,      // Levels the outside devices drive.
  output logic      [7:0] pad_in_o    // Resolved pad levels.
);
  // Outside devices drive only released pins, never fighting the block.
  assign pad_in_o = (pad_out_i & ~pad_oe_n_i) | (ext_i & pad_oe_n_i);
endmodule : pfs_pad_partner

//--- verif/tb.sv
// Self-checking testbench of the upper port pin function select block.
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0;     // Block clock.
  logic        rst = 1'b1;     // Power-on reset.
  logic        hsel = 1'b0;    // Bus select.
  logic [1:0]  htrans = 2'h0;  // Transfer type.
  logic        hwrite = 1'b0;  // Write when high.
  logic [2:0]  hsize = 3'h2;   // Always a whole word.
  logic [31:0] haddr = 32'h0;  // Byte address.
  logic [31:0] hwdata = 32'h0; // Write data.
  logic [31:0] hrdata;         // Read data.
  logic        hready;         // Ready, looped back.
  logic [3:0]  m = 4'h8;       // Present, single chip, ROM off, area 0 wide.
  logic [7:0]  gout = 8'h5A, gdir = 8'h0F, dout = 8'h96, alt = 8'h54, ext = 8'h62;
  logic [7:0]  pad_in, pad_out, pad_oe_n, gin, din, e_oe, e_out, e_gin, e_din;
  logic [2:0]  ain, e_ain;     // Trigger, request 1, request 0.
  logic [15:0] selb;           // Companion register value.
  int          fail_count = 0; // Mismatches.
  int          checks = 0;     // Comparisons.
  always #2 clk = ~clk;
  pfs_upper_pin_select dut (.CLOCK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
    .SINGLE_CHIP_I(m[2]), .ROM_OFF_I(m[1]), .AREA0_WIDE_I(m[0]), .PINS_PRESENT_I(m[3]),
    .PAD_IN_I(pad_in), .PAD_OUT_O(pad_out), .PAD_OE_N_O(pad_oe_n), .GPIO_OUT_I(gout),
    .GPIO_DIR_I(gdir), .GPIO_IN_O(gin), .DBUS_OUT_I(dout), .DBUS_OE_I(1'b1),
    .DBUS_IN_O(din), .IRQ_ACCEPTED_OUT_N_I(alt[6]), .CHIP_SELECT_3_N_I(alt[5]),
    .CHIP_SELECT_2_N_I(alt[4]), .DMA_ACK_CH1_I(alt[3]), .DMA_ACK_CH0_I(alt[2]),
    .ADC_TRIGGER_IN_N_O(ain[2]), .DMA_REQ_CH1_N_O(ain[1]), .DMA_REQ_CH0_N_O(ain[0]),
    .SELECT_B_O(selb));
  pfs_pad_partner u_pads (.pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n), .ext_i(ext),
    .pad_in_o(pad_in));
  // Prints the verdict and ends the run.
  task automatic complete_run;
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Compares one value and reports a mismatch at once.
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // Waits for an edge with ready high; a hang ends the run.
  task automatic wait_ready;
    int n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        check("bus ready", 32'h1, 32'h0);
        complete_run();
      end
      @(posedge clk);
    end
  endtask : wait_ready
  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus
  // Works out the pins from the select value and mode.
  task automatic model(input logic [15:0] sel);
    logic [1:0] f, k;
    logic       w;
    e_ain = 3'h7;
    for (int i = 0; i < 8; i++)
    begin
      f = sel[2*i+:2];
      k = (m[2] && f == 2'h1) ? 2'h0 : f;
      if (m[2] && f == 2'h2)
        k = (i == 7) ? 2'h2 : (i == 6) ? 2'h3 : 2'h0;
      if (m[1] && m[0])
        k = 2'h1;
      if (!m[3])
        k = 2'h3;
      e_oe[i] = (k == 2'h0) ? ~gdir[i] : !(k == 2'h1 || (k == 2'h2 && i > 1 && i < 7));
      e_out[i] = (k == 2'h0) ? gout[i] : (k == 2'h1) ? dout[i] : alt[i];
      w = e_oe[i] ? ext[i] : e_out[i];
      e_gin[i] = (k == 2'h0) & w;
      e_din[i] = (k == 2'h1) & w;
      if (k == 2'h2 && (i < 2 || i == 7))
        e_ain[(i == 7) ? 2 : i] = w;
    end
    e_out = e_out & ~e_oe;
  endtask : model
  // Sets a mode, writes and reads back select a, then judges every pin.
  task automatic t_decode(input logic [15:0] sel, input logic [3:0] mode);
    logic [31:0] rd;
    m <= mode;
    bus(1'b1, 12'h000, {16'hFFFF, sel}, rd);
    bus(1'b0, 12'h000, 32'h0, rd);
    check("select a", {16'h0, sel}, rd);
    repeat (8) @(posedge clk);
    model(sel);
    check("pad enables", {24'h0, e_oe}, {24'h0, pad_oe_n});
    check("pad levels", {24'h0, e_out}, {24'h0, pad_out & ~pad_oe_n});
    check("port in", {24'h0, e_gin}, {24'h0, gin});
    check("bus in", {24'h0, e_din}, {24'h0, din});
    check("alt in", {29'h0, e_ain}, {29'h0, ain});
  endtask : t_decode
  // Reset values, the upper half, an unmapped place and a second reset.
  task automatic t_regs;
    logic [31:0] rd;
    bus(1'b0, 12'h004, 32'h0, rd);
    check("select b reset", 32'h0, rd);
    bus(1'b1, 12'h004, 32'hFFFF_AAAA, rd);
    bus(1'b0, 12'h004, 32'h0, rd);
    check("select b", 32'h0000_AAAA, rd);
    check("select b out", 32'h0000_AAAA, {16'h0, selb});
    bus(1'b1, 12'h008, 32'h0000_5555, rd);
    bus(1'b0, 12'h008, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    bus(1'b0, 12'h000, 32'h0, rd);
    check("select a kept", 32'h0, rd);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 12'h004, 32'h0, rd);
    check("select b cleared", 32'h0, rd);
  endtask : t_regs
  // Software writes only codes 00, 01 and 10 into any field.
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_decode(16'h0000, 4'h8);
    t_decode(16'h5555, 4'h8);
    t_decode(16'hAAAA, 4'h8);
    t_decode(16'h9862, 4'h8);
    t_decode(16'h5555, 4'hC);
    t_decode(16'hAAAA, 4'hC);
    t_decode(16'h9862, 4'hC);
    t_decode(16'hAAAA, 4'hB);
    t_decode(16'h5555, 4'hA);
    t_decode(16'h9862, 4'h0);
    complete_run();
  end
endmodule : tb
bind pfs_upper_pin_select pfs_sel_chk u_chk (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .SINGLE_CHIP_I(SINGLE_CHIP_I),
  .ROM_OFF_I(ROM_OFF_I), .AREA0_WIDE_I(AREA0_WIDE_I), .PINS_PRESENT_I(PINS_PRESENT_I),
  .PAD_OUT_O(PAD_OUT_O), .PAD_OE_N_O(PAD_OE_N_O), .GPIO_OUT_I(GPIO_OUT_I),
  .GPIO_DIR_I(GPIO_DIR_I), .GPIO_IN_O(GPIO_IN_O), .DBUS_OUT_I(DBUS_OUT_I),
  .DBUS_OE_I(DBUS_OE_I), .DBUS_IN_O(DBUS_IN_O), .ADC_TRIGGER_IN_N_O(ADC_TRIGGER_IN_N_O),
  .DMA_REQ_CH1_N_O(DMA_REQ_CH1_N_O), .DMA_REQ_CH0_N_O(DMA_REQ_CH0_N_O),
  .SELECT_B_O(SELECT_B_O));
